// ===== hdl/psr_pkg.sv
`default_nettype none
package psr_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned CLK_PERIOD_NS  = 4;
  // phase-detector rate that paces the auxiliary port
  localparam int unsigned AUX_CLK_MHZ    = 25;
  localparam logic [3:0]  AUX_HALF       = 4'(CLK_MHZ / (2 * AUX_CLK_MHZ));
  // serial clock made by the host end
  localparam int unsigned SCLK_PERIOD_NS = 80;
  localparam logic [4:0]  SCLK_HALF      = 5'(SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));

  // ----------------------------------------------------------------
  // frame layout: data, register address, chip address, msb first
  // ----------------------------------------------------------------
  localparam logic [5:0]  FRAME_BITS     = 6'h20;
  localparam logic [4:0]  LAST_BIT       = 5'h1F;
  localparam int unsigned CHIP_LSB       = 0;
  localparam int unsigned REGA_LSB       = 3;
  localparam int unsigned DATA_LSB       = 8;
  localparam logic [2:0]  CHIP_ADDR      = 3'h0;

  // ----------------------------------------------------------------
  // device register map
  // ----------------------------------------------------------------
  localparam logic [4:0]  REG_ID_PTR     = 5'h00;
  localparam logic [4:0]  REG_PWR        = 5'h01;
  localparam logic [4:0]  REG_FREQ_INT   = 5'h03;
  localparam logic [4:0]  REG_FREQ_FRAC  = 5'h04;
  localparam logic [4:0]  REG_AUX        = 5'h05;
  localparam int unsigned SOFT_RST_BIT   = 5;
  localparam int unsigned PTR_MSB        = 4;
  // identity value is arbitrary
  localparam logic [23:0] ID_CODE        = 24'h5A0C31;
  localparam logic [4:0]  PTR_RESET      = 5'h00;
  localparam logic [8:0]  PWR_RESET      = 9'h002;
  localparam logic [15:0] AUX_RESET      = 16'h0000;
  localparam int unsigned PWR_PIN_SEL    = 0;
  localparam int unsigned PWR_SPI_EN     = 1;
  localparam int unsigned PWR_HOLD_LSB   = 2;
  localparam int unsigned PWR_HOLD_MSB   = 7;

  // ----------------------------------------------------------------
  // auxiliary port: 16 data cycles then 4 overhead cycles
  // ----------------------------------------------------------------
  localparam logic [4:0]  AUX_DATA_CYC   = 5'h10;
  localparam logic [4:0]  AUX_LAST_CYC   = 5'h13;
  localparam logic [4:0]  AUX_STB_CYC    = 5'h11;

  // ----------------------------------------------------------------
  // host command registers
  // ----------------------------------------------------------------
  localparam logic [7:0]  HOST_TX        = 8'h00;
  localparam logic [7:0]  HOST_CMD       = 8'h04;
  localparam logic [7:0]  HOST_RX        = 8'h08;
  localparam logic [7:0]  HOST_STAT      = 8'h0C;
  localparam int unsigned STAT_BUSY      = 0;
  localparam int unsigned STAT_DONE      = 1;

  typedef enum logic [1:0] {MODE_UNSET, MODE_OPEN, MODE_LEGACY} psr_mode_t;
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_GAP, H_STB} psr_hstate_t;
endpackage : psr_pkg
`default_nettype wire

// ===== hdl/psr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface psr_link_if;
  logic sclk;
  logic sdi;
  logic frame_strobe;
  logic lock_or_readback_out;
  logic lock_or_readback_oe;
  logic sdo_line;

  // released line reads low, as with a weak pull-down
  assign sdo_line = lock_or_readback_oe & lock_or_readback_out;

  modport dev (
    input  sclk,
    input  sdi,
    input  frame_strobe,
    output lock_or_readback_out,
    output lock_or_readback_oe
  );
  modport host (
    output sclk,
    output sdi,
    output frame_strobe,
    input  sdo_line
  );
endinterface : psr_link_if
`default_nettype wire

// ===== hdl/psr_host.sv
`timescale 1ns/1ps
`default_nettype none
module psr_host
  import psr_pkg::*;
(
  // system
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // serial link
  psr_link_if.host         link
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [23:0] tx_ff;
  logic [31:0] sh_ff;
  logic [31:0] rx_sh_ff;
  logic [23:0] rx_ff;
  logic        done_ff;
  logic [31:0] rdata_ff;
  logic [4:0]  div_ff;
  logic [4:0]  idx_ff;
  logic        sclk_ff;
  logic        sdi_ff;
  logic        stb_ff;
  logic [1:0]  sdo_sync_ff;
  psr_hstate_t st_ff;

  wire half_end = div_ff == SCLK_HALF - 5'h01;
  wire busy     = st_ff != H_IDLE;
  wire start    = wr_i & (addr_i == HOST_CMD) & ~busy;
  wire frame_end = (st_ff == H_STB) & half_end;
  wire done_clr = wr_i & (addr_i == HOST_STAT) & wdata_i[STAT_DONE];
  wire [31:0] rd_mux =
    (addr_i == HOST_TX)   ? {8'h00, tx_ff} :
    (addr_i == HOST_RX)   ? {8'h00, rx_ff} :
    (addr_i == HOST_STAT) ? {30'h0, done_ff, busy} : 32'h0000_0000;

  assign rdata_o           = rdata_ff;
  assign link.sclk         = sclk_ff;
  assign link.sdi          = sdi_ff;
  assign link.frame_strobe = stb_ff;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_ff    <= 24'h000000;
      rdata_ff <= 32'h0000_0000;
      done_ff  <= 1'b0;
      sdo_sync_ff <= 2'b00;
    end else begin
      sdo_sync_ff <= {sdo_sync_ff[0], link.sdo_line};
      rdata_ff <= rd_i ? rd_mux : 32'h0000_0000;
      if (wr_i && addr_i == HOST_TX) begin
        tx_ff <= wdata_i[23:0];
      end
      // a frame ending in the clearing cycle still leaves done set
      if (frame_end) begin
        done_ff <= 1'b1;
      end else if (done_clr) begin
        done_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // frame engine: sdi changes on falling sclk, sdo taken on falling
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff    <= H_IDLE;
      div_ff   <= 5'h00;
      idx_ff   <= 5'h00;
      sclk_ff  <= 1'b0;
      sdi_ff   <= 1'b0;
      stb_ff   <= 1'b0;
      sh_ff    <= 32'h0000_0000;
      rx_sh_ff <= 32'h0000_0000;
      rx_ff    <= 24'h000000;
    end else begin
      div_ff <= (st_ff == H_IDLE || half_end) ? 5'h00 : div_ff + 5'h01;
      unique case (st_ff)
        H_IDLE: begin
          if (start) begin
            sh_ff  <= {tx_ff, wdata_i[REGA_LSB +: 5], wdata_i[CHIP_LSB +: 3]};
            sdi_ff <= tx_ff[23];
            idx_ff <= 5'h00;
            st_ff  <= H_LOW;
          end
        end
        H_LOW: begin
          if (half_end) begin
            sclk_ff <= 1'b1;
            st_ff   <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (half_end) begin
            sclk_ff  <= 1'b0;
            rx_sh_ff <= {rx_sh_ff[30:0], sdo_sync_ff[1]};
            if (idx_ff == LAST_BIT) begin
              st_ff <= H_GAP;
            end else begin
              idx_ff <= idx_ff + 5'h01;
              sh_ff  <= {sh_ff[30:0], 1'b0};
              sdi_ff <= sh_ff[30];
              st_ff  <= H_LOW;
            end
          end
        end
        H_GAP: begin
          if (half_end) begin
            stb_ff <= 1'b1;
            st_ff  <= H_STB;
          end
        end
        H_STB: begin
          if (half_end) begin
            stb_ff <= 1'b0;
            rx_ff  <= rx_sh_ff[31:DATA_LSB];
            st_ff  <= H_IDLE;
          end
        end
        // unused state codes fall back to idle
        default: begin
          st_ff <= H_IDLE;
        end
      endcase
    end
  end
endmodule : psr_host
`default_nettype wire

// ===== hdl/psr_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - every transfer outputs register picked by pointer, except one after a foreign-chip frame
// - unchanged pointer repeats same contents each transfer
// - output pin driven during writes too
// - frame is 24 data, 5 register, 3 chip
// - host writes pointer register with upper bits zero
// - pointer write uses register address zero
// - only chip address zero is answered
// - strobe after 32nd edge commits the frame
// - host may resend same frame during read-back
// - read-back shifts out on 32 edges, no lock
// - lock returns only on strobe after 32 edges
// - foreign chip address releases the output pin
// - frequency change sends auxiliary register out
// - auxiliary port: 16 data plus 4 overhead cycles
// - register zero reads fixed identity code
// - bit 5 of register zero soft-resets registers and ports, but not the protocol mode
// - bits 4..0 of register zero set pointer
// - register 1 bit 0 selects pin enable
// - otherwise register 1 bit 1 enables chip
// - register 1 bits 2..7 hold blocks powered
// - first edge after power-up fixes the protocol
module psr_dev
  import psr_pkg::*;
(
  // system
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // serial link
  psr_link_if.dev          link,
  // analog side status and pins
  input  wire logic        lock_detect_i,
  input  wire logic        external_enable_pin_i,
  // power control and protocol mode
  output logic             chip_enable_o,
  output logic [5:0]       block_power_o,
  output logic             legacy_framed_mode_o,
  // auxiliary serial port
  output logic             aux_clk_o,
  output logic             auxiliary_data_pin_o,
  output logic             aux_strobe_o
);
  // ----------------------------------------------------------------
  // pin synchronisers: sclk, sdi, strobe, enable pin
  // ----------------------------------------------------------------
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic       sclk_prev_ff;
  logic       stb_prev_ff;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_ff      <= 4'h0;
      sync_ff      <= 4'h0;
      sclk_prev_ff <= 1'b0;
      stb_prev_ff  <= 1'b0;
    end else begin
      meta_ff      <= {link.sclk, link.sdi, link.frame_strobe, external_enable_pin_i};
      sync_ff      <= meta_ff;
      sclk_prev_ff <= sync_ff[3];
      stb_prev_ff  <= sync_ff[1];
    end
  end

  wire sclk_rise = sync_ff[3] & ~sclk_prev_ff;
  wire stb_rise  = sync_ff[1] & ~stb_prev_ff;
  wire sdi_s     = sync_ff[2];
  wire en_pin_s  = sync_ff[0];

  // ----------------------------------------------------------------
  // protocol decision
  // ----------------------------------------------------------------
  psr_mode_t mode_ff;

  // a strobe and a clock edge in the same cycle count as strobe first
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_ff <= MODE_UNSET;
    end else if (mode_ff == MODE_UNSET) begin
      if (stb_rise) begin
        mode_ff <= MODE_LEGACY;
      end else if (sclk_rise) begin
        mode_ff <= MODE_OPEN;
      end
    end
  end

  wire open_mode = mode_ff == MODE_OPEN;
  // the deciding clock edge is already the frame's first bit
  wire bit_take  = sclk_rise & (open_mode | (mode_ff == MODE_UNSET & ~stb_rise));

  assign legacy_framed_mode_o = mode_ff == MODE_LEGACY;

  // ----------------------------------------------------------------
  // frame shift and decode
  // ----------------------------------------------------------------
  logic [31:0] sh_ff;
  logic [5:0]  cnt_ff;
  logic [4:0]  ptr_ff;
  logic [8:0]  pwr_ff;
  logic [15:0] aux_ff;

  wire        full     = cnt_ff == FRAME_BITS;
  wire        commit   = open_mode & stb_rise & full;
  wire [2:0]  chip_f   = sh_ff[CHIP_LSB +: 3];
  wire [4:0]  rega_f   = sh_ff[REGA_LSB +: 5];
  wire [23:0] data_f   = sh_ff[DATA_LSB +: 24];
  wire        chip_ok  = chip_f == CHIP_ADDR;
  wire        wr       = commit & chip_ok;
  wire        wr_r0    = wr & (rega_f == REG_ID_PTR);
  wire        soft_rst = wr_r0 & data_f[SOFT_RST_BIT];
  wire        clr      = srst_i | soft_rst;
  wire        freq_chg = wr & ~soft_rst &
                         (rega_f == REG_FREQ_INT | rega_f == REG_FREQ_FRAC);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sh_ff  <= 32'h0000_0000;
      cnt_ff <= 6'h00;
    end else if (open_mode && stb_rise) begin
      // a strobe before the 32nd edge discards the partial frame
      cnt_ff <= 6'h00;
    end else if (bit_take) begin
      sh_ff  <= {sh_ff[30:0], sdi_s};
      cnt_ff <= full ? cnt_ff : cnt_ff + 6'h01;
    end
  end

  // soft reset wins over the pointer written in the same frame
  always_ff @(posedge clk_i) begin
    if (clr) begin
      ptr_ff <= PTR_RESET;
      pwr_ff <= PWR_RESET;
      aux_ff <= AUX_RESET;
    end else begin
      if (wr_r0) begin
        ptr_ff <= data_f[PTR_MSB:0];
      end
      if (wr && rega_f == REG_PWR) begin
        pwr_ff <= data_f[8:0];
      end
      if (wr && rega_f == REG_AUX) begin
        aux_ff <= data_f[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read-back on the shared pin
  // ----------------------------------------------------------------
  logic [31:0] out_ff;
  logic        rb_ff;
  logic        mute_ff;
  logic        sdo_ff;
  logic        oe_ff;

  // the pointer register itself is write-only, so address 0 gives the identity
  wire [23:0] rd_word =
    (ptr_ff == REG_ID_PTR) ? ID_CODE :
    (ptr_ff == REG_PWR)    ? {15'h0000, pwr_ff} :
    (ptr_ff == REG_AUX)    ? {8'h00, aux_ff} : 24'h000000;

  wire nxt_sdo = rb_ff ? out_ff[31] : lock_detect_i;
  // chip address is only known after the 32nd bit; release at once then
  wire nxt_oe  = open_mode & ~mute_ff & ~(rb_ff & full & ~chip_ok);

  always_ff @(posedge clk_i) begin
    if (clr) begin
      out_ff  <= 32'h0000_0000;
      rb_ff   <= 1'b0;
      mute_ff <= 1'b0;
    end else begin
      if (bit_take && cnt_ff == 6'h00) begin
        out_ff <= {rd_word, 8'h00};
        rb_ff  <= 1'b1;
      end else if (bit_take) begin
        out_ff <= {out_ff[30:0], 1'b0};
      end else if (commit) begin
        rb_ff  <= 1'b0;
      end
      if (commit) begin
        mute_ff <= ~chip_ok;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sdo_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end else begin
      sdo_ff <= nxt_sdo;
      oe_ff  <= nxt_oe;
    end
  end

  assign link.lock_or_readback_out = sdo_ff;
  assign link.lock_or_readback_oe  = oe_ff;

  // ----------------------------------------------------------------
  // power control
  // ----------------------------------------------------------------
  logic       chip_en_ff;
  logic [5:0] blk_ff;

  wire nxt_chip_en = pwr_ff[PWR_PIN_SEL] ? en_pin_s : pwr_ff[PWR_SPI_EN];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      chip_en_ff <= 1'b0;
      blk_ff     <= 6'h00;
    end else begin
      chip_en_ff <= nxt_chip_en;
      blk_ff     <= pwr_ff[PWR_HOLD_MSB:PWR_HOLD_LSB] | {6{nxt_chip_en}};
    end
  end

  assign chip_enable_o = chip_en_ff;
  assign block_power_o = blk_ff;

  // ----------------------------------------------------------------
  // auxiliary serial port
  // ----------------------------------------------------------------
  logic        aux_busy_ff;
  logic [3:0]  aux_div_ff;
  logic [4:0]  aux_idx_ff;
  logic [15:0] aux_sh_ff;
  logic        aux_clk_ff;
  logic        aux_dat_ff;
  logic        aux_stb_ff;

  wire aux_tick = aux_busy_ff & (aux_div_ff == AUX_HALF - 4'h1);
  wire aux_fall = aux_tick & aux_clk_ff;
  wire [4:0] aux_nxt_idx = aux_idx_ff + 5'h01;

  // a frequency change during a running transfer is not queued
  always_ff @(posedge clk_i) begin
    if (clr) begin
      aux_busy_ff <= 1'b0;
      aux_div_ff  <= 4'h0;
      aux_idx_ff  <= 5'h00;
      aux_sh_ff   <= 16'h0000;
      aux_clk_ff  <= 1'b0;
      aux_dat_ff  <= 1'b0;
      aux_stb_ff  <= 1'b0;
    end else if (!aux_busy_ff) begin
      if (freq_chg) begin
        aux_busy_ff <= 1'b1;
        aux_sh_ff   <= aux_ff;
        aux_dat_ff  <= aux_ff[15];
        aux_idx_ff  <= 5'h00;
        aux_div_ff  <= 4'h0;
      end
    end else begin
      aux_div_ff <= aux_tick ? 4'h0 : aux_div_ff + 4'h1;
      if (aux_tick) begin
        aux_clk_ff <= ~aux_clk_ff;
      end
      if (aux_fall && aux_idx_ff == AUX_LAST_CYC) begin
        aux_busy_ff <= 1'b0;
        aux_stb_ff  <= 1'b0;
        aux_dat_ff  <= 1'b0;
      end else if (aux_fall) begin
        aux_idx_ff <= aux_nxt_idx;
        aux_sh_ff  <= {aux_sh_ff[14:0], 1'b0};
        aux_dat_ff <= (aux_nxt_idx < AUX_DATA_CYC) ? aux_sh_ff[14] : 1'b0;
        aux_stb_ff <= aux_nxt_idx == AUX_STB_CYC;
      end
    end
  end

  assign aux_clk_o            = aux_clk_ff;
  assign auxiliary_data_pin_o = aux_dat_ff;
  assign aux_strobe_o         = aux_stb_ff;
endmodule : psr_dev
`default_nettype wire

// ===== dv/psr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module psr_monitor
  import psr_pkg::*;
(
  // system
  input wire logic clk_i,
  input wire logic srst_i,
  // link
  input wire logic sclk,
  input wire logic sdi,
  input wire logic frame_strobe,
  input wire logic lock_or_readback_out,
  input wire logic lock_or_readback_oe,
  input wire logic lock_detect_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // ------------------------------------------------------------
  // frame tracking
  // ------------------------------------------------------------
  logic        sclk_q_ff;
  logic        stb_q_ff;
  logic        last_ok_ff;
  logic [5:0]  cnt_ff;
  logic [3:0]  since_ff;
  logic [31:0] sh_ff;
  wire         rise     = sclk & ~sclk_q_ff;
  wire         stb_fall = ~frame_strobe & stb_q_ff;
  // a soft reset may clear the read-back state, so those frames are left out
  wire         soft_rst = (sh_ff[7:3] == REG_ID_PTR) & sh_ff[13];

  always_ff @(posedge clk_i) begin
    sclk_q_ff <= srst_i ? 1'b0 : sclk;
    stb_q_ff  <= srst_i ? 1'b0 : frame_strobe;
    if (srst_i | (frame_strobe & ~stb_q_ff)) cnt_ff <= 6'h00;
    else if (rise) cnt_ff <= cnt_ff + 6'h01;
    if (srst_i | rise) since_ff <= 4'h0;
    else if (since_ff != 4'hF) since_ff <= since_ff + 4'h1;
    if (rise) sh_ff <= {sh_ff[30:0], sdi};
    if (srst_i) last_ok_ff <= 1'b0;
    else if (stb_fall) last_ok_ff <= (sh_ff[2:0] == CHIP_ADDR) & ~soft_rst;
  end

  a_sdi_moves_low: assert property ($changed(sdi) |-> !sclk)
    else $error("sdi changed while sclk high");
  a_strobe_after_32: assert property ($rose(frame_strobe) |-> cnt_ff == 6'h20)
    else $error("strobe raised without 32 clock edges");
  a_strobe_sclk_low: assert property (frame_strobe |-> !sclk)
    else $error("sclk high while strobe high");
  a_strobe_width: assert property ($rose(frame_strobe) |-> frame_strobe[*3])
    else $error("strobe pulse too short");
  a_lock_muted: assert property (cnt_ff != 6'h00 && lock_or_readback_oe
    && $changed(lock_or_readback_out) |-> since_ff < 4'h8)
    else $error("data out moved away from a clock edge in a frame");
  a_lock_restored: assert property ($fell(frame_strobe) && lock_or_readback_oe && !soft_rst
    && $past(lock_detect_i, 3) == lock_detect_i && $past(lock_detect_i) == lock_detect_i
    |-> lock_or_readback_out == lock_detect_i)
    else $error("lock detect not restored after strobe");
  a_foreign_released: assert property ($fell(frame_strobe) && !soft_rst
    |-> lock_or_readback_oe == (sh_ff[2:0] == CHIP_ADDR))
    else $error("output enable does not follow chip match");
  a_driven_in_frame: assert property (rise && cnt_ff < 6'h1D && last_ok_ff
    |-> lock_or_readback_oe)
    else $error("data out released during a frame");

  c_readback: cover property ($fell(frame_strobe) && sh_ff[7:3] == REG_ID_PTR);
  c_foreign: cover property ($fell(frame_strobe) && sh_ff[2:0] != CHIP_ADDR);
  c_freq: cover property ($rose(frame_strobe) && sh_ff[7:3] == REG_FREQ_INT);
endmodule : psr_monitor
`default_nettype wire

// ===== dv/pll_serial_readback_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, nm) begin num_checks++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module pll_serial_readback_ctrl_tb
  import psr_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        lock_det = 1'b0;
  logic        ext_pin = 1'b0;
  logic        chip_en, leg_mode, leg_mode2, aux_clk, aux_pin, aux_stb;
  logic [5:0]  blk_pwr;
  logic        sc_q = 1'b0, st_q = 1'b0, ac_q = 1'b0, as_q = 1'b0;
  logic [31:0] fr_sh = 32'h0, fr_last = 32'h0;
  logic [5:0]  fr_n = 6'h00, n_last = 6'h00;
  logic [19:0] aux_sh = 20'h0;
  int          aux_n = 0, aux_sn = 0, errors = 0, num_checks = 0;
  integer      seed = 32'h0420DA04;

  psr_link_if link();
  psr_link_if link2();

  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  psr_host i_psr_host (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link(link));
  psr_dev i_psr_dev (.clk_i(clk_i), .srst_i(srst_i), .link(link), .lock_detect_i(lock_det),
    .external_enable_pin_i(ext_pin), .chip_enable_o(chip_en), .block_power_o(blk_pwr),
    .legacy_framed_mode_o(leg_mode), .aux_clk_o(aux_clk), .auxiliary_data_pin_o(aux_pin),
    .aux_strobe_o(aux_stb));
  // second device on a link driven by the bench alone
  psr_dev i_psr_dev_leg (.clk_i(clk_i), .srst_i(srst_i), .link(link2), .lock_detect_i(lock_det),
    .external_enable_pin_i(ext_pin), .chip_enable_o(), .block_power_o(),
    .legacy_framed_mode_o(leg_mode2), .aux_clk_o(), .auxiliary_data_pin_o(), .aux_strobe_o());
  psr_monitor i_psr_monitor (.clk_i(clk_i), .srst_i(srst_i), .sclk(link.sclk), .sdi(link.sdi),
    .frame_strobe(link.frame_strobe), .lock_or_readback_out(link.lock_or_readback_out),
    .lock_or_readback_oe(link.lock_or_readback_oe), .lock_detect_i(lock_det));

  // ------------------------------------------------------------
  // wire and auxiliary port observers
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    sc_q <= link.sclk;
    st_q <= link.frame_strobe;
    ac_q <= aux_clk;
    as_q <= aux_stb;
    if (link.sclk && !sc_q) begin
      fr_sh <= {fr_sh[30:0], link.sdi};
      fr_n  <= fr_n + 6'h01;
    end
    if (link.frame_strobe && !st_q) begin
      fr_last <= fr_sh;
      n_last  <= fr_n;
      fr_n    <= 6'h00;
    end
    if (aux_clk && !ac_q) begin
      aux_sh <= {aux_sh[18:0], aux_pin};
      aux_n  <= aux_n + 1;
    end
    if (aux_stb && !as_q) aux_sn <= aux_sn + 1;
    // lock toggles freely so a leak onto the data pin shows up
    if (($random(seed) & 7) == 0) lock_det <= ~lock_det;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    @(posedge clk_i);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk_i);
  endtask : rd_reg

  // one whole frame; rx holds what came back on the data pin
  task automatic frame(input logic [23:0] d, input logic [4:0] r, input logic [2:0] c,
                       output logic [23:0] rx);
    logic [31:0] v;
    wr_reg(HOST_TX, {8'h00, d});
    wr_reg(HOST_CMD, {24'h0, r, c});
    v = 32'h0;
    for (int i = 0; i < 1000 && !v[STAT_DONE]; i++) rd_reg(HOST_STAT, v);
    `CHK(v[STAT_DONE], 1'b1, "frame done");
    wr_reg(HOST_STAT, 32'h2);
    rd_reg(HOST_RX, v);
    rx = v[23:0];
    `CHK(fr_last, {d, r, c}, "wire bits");
    `CHK(n_last, 6'h20, "clock edges");
    `CHK(link.sclk, 1'b0, "sclk idle");
  endtask : frame

  function automatic logic [6:0] exp_pwr(input logic [8:0] r, input logic pin);
    logic ce;
    ce = r[PWR_PIN_SEL] ? pin : r[PWR_SPI_EN];
    return {r[PWR_HOLD_MSB:PWR_HOLD_LSB] | {6{ce}}, ce};
  endfunction : exp_pwr

  initial begin
    #(CLK_PERIOD_NS * 60000);
    errors++;
    stop_test;
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    logic [23:0] rx;
    logic [8:0]  r1;
    logic [15:0] av;
    int          n0;
    int          s0;
    link2.sclk = 1'b0;
    link2.sdi = 1'b0;
    link2.frame_strobe = 1'b0;
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    frame(24'h0, REG_ID_PTR, CHIP_ADDR, rx);
    frame(24'h0, REG_ID_PTR, CHIP_ADDR, rx);
    `CHK(rx, ID_CODE, "identity");
    for (int i = 0; i < 4; i++) begin
      r1 = {1'b0, 6'($random(seed)), 2'(i)};
      ext_pin <= 1'($random(seed));
      frame({15'h0, r1}, REG_PWR, CHIP_ADDR, rx);
      `CHK({blk_pwr, chip_en}, exp_pwr(r1, ext_pin), "power");
      ext_pin <= ~ext_pin;
      repeat (8) @(posedge clk_i);
      `CHK({blk_pwr, chip_en}, exp_pwr(r1, ext_pin), "power pin");
    end
    frame(24'h1, REG_ID_PTR, CHIP_ADDR, rx);
    `CHK(rx, ID_CODE, "old pointer");
    frame(24'h1, REG_ID_PTR, CHIP_ADDR, rx);
    `CHK(rx, {15'h0, r1}, "power readback");
    frame(24'h1, REG_ID_PTR, CHIP_ADDR, rx);
    `CHK(rx, {15'h0, r1}, "power repeat");
    frame(24'h0FC, REG_PWR, 3'h5, rx);
    `CHK(link.lock_or_readback_oe, 1'b0, "released");
    frame(24'h1, REG_ID_PTR, CHIP_ADDR, rx);
    frame(24'h1, REG_ID_PTR, CHIP_ADDR, rx);
    `CHK(rx, {15'h0, r1}, "foreign ignored");
    av = 16'($random(seed));
    frame({8'h00, av}, REG_AUX, CHIP_ADDR, rx);
    n0 = aux_n;
    s0 = aux_sn;
    frame(24'h0, REG_FREQ_FRAC, 3'h7, rx);
    `CHK(aux_n, n0, "foreign no aux");
    frame(24'h0, REG_FREQ_INT, CHIP_ADDR, rx);
    repeat (300) @(posedge clk_i);
    `CHK(aux_n - n0, int'(AUX_LAST_CYC) + 1, "aux cycles");
    `CHK(aux_sn - s0, 1, "aux strobe");
    `CHK(aux_sh[19:4], av, "aux data");
    frame(24'h0, REG_FREQ_FRAC, CHIP_ADDR, rx);
    repeat (300) @(posedge clk_i);
    `CHK(aux_sn - s0, 2, "aux frac strobe");
    `CHK(aux_sh[19:4], av, "aux frac data");
    frame(24'h5, REG_ID_PTR, CHIP_ADDR, rx);
    frame(24'h5, REG_ID_PTR, CHIP_ADDR, rx);
    `CHK(rx, {8'h00, av}, "aux readback");
    frame(24'h20, REG_ID_PTR, CHIP_ADDR, rx);
    `CHK({blk_pwr, chip_en}, exp_pwr(PWR_RESET, ext_pin), "soft reset power");
    frame(24'h1, REG_ID_PTR, CHIP_ADDR, rx);
    `CHK(rx, ID_CODE, "soft reset pointer");
    frame(24'h1, REG_ID_PTR, CHIP_ADDR, rx);
    `CHK(rx, {15'h0, PWR_RESET}, "soft reset reg1");
    `CHK(leg_mode, 1'b0, "open mode");
    link2.frame_strobe <= 1'b1;
    repeat (10) @(posedge clk_i);
    link2.frame_strobe <= 1'b0;
    repeat (64) begin
      link2.sclk <= ~link2.sclk;
      link2.sdi  <= 1'($random(seed));
      repeat (10) @(posedge clk_i);
    end
    `CHK(leg_mode2, 1'b1, "legacy mode");
    `CHK(link2.lock_or_readback_oe, 1'b0, "legacy quiet");
    stop_test;
  end
endmodule : pll_serial_readback_ctrl_tb
`default_nettype wire
